// File: inc/pkdm_pkg.sv
/*
 * Shared constants for the front-panel keypad and display menu controller:
 * clock rate, the documented hold and display times, key indices, state codes
 * and save result codes.
 * Assumes a single 250 MHz system clock and a synchronous active-high reset.
 */
`default_nettype none

package pkdm_pkg;

    // System clock rate.
    localparam longint CLK_HZ = 250_000_000;

    // Times in milliseconds, as the panel behaviour defines them.
    localparam longint T_SHOW_MS     = 1000;
    localparam longint T_IDLE_MS     = 20000;
    localparam longint T_HOLD_MS     = 2000;
    localparam longint T_DEBOUNCE_MS = 10;

    // Cycle counts derived from the times; a 33-bit width holds 20 s of cycles.
    localparam logic [32:0] SHOW_CYC     = 33'(CLK_HZ / 1000 * T_SHOW_MS);
    localparam logic [32:0] IDLE_CYC     = 33'(CLK_HZ / 1000 * T_IDLE_MS);
    localparam logic [32:0] HOLD_CYC     = 33'(CLK_HZ / 1000 * T_HOLD_MS);
    localparam logic [32:0] DEBOUNCE_CYC = 33'(CLK_HZ / 1000 * T_DEBOUNCE_MS);

    // Key positions inside the key vector.
    localparam int K_MODE  = 0;
    localparam int K_SHIFT = 1;
    localparam int K_UP    = 2;
    localparam int K_DOWN  = 3;
    localparam int K_SET   = 4;
    localparam int N_KEYS  = 5;

    // Monitor variable count, parameter group count and parameter numbers.
    localparam logic [4:0] MON_COUNT   = 5'h13;
    localparam logic [3:0] GROUP_COUNT = 4'h5;
    localparam logic [7:0] PNUM_COUNT  = 8'h64;

    // Save result codes reported by the parameter store.
    localparam logic [2:0] RES_SAVED     = 3'h0;
    localparam logic [2:0] RES_READ_ONLY = 3'h1;
    localparam logic [2:0] RES_LOCKED    = 3'h2;
    localparam logic [2:0] RES_RANGE     = 3'h3;
    localparam logic [2:0] RES_SERVO_ON  = 3'h4;
    localparam logic [2:0] RES_POWER_ON  = 3'h5;

    // Menu states; the code is also the display kind seen outside.
    typedef enum logic [2:0] {
        ST_BOOT   = 3'h0,
        ST_MONSYM = 3'h1,
        ST_MON    = 3'h2,
        ST_PARAM  = 3'h3,
        ST_EDIT   = 3'h4,
        ST_SAVEW  = 3'h5,
        ST_RESULT = 3'h6,
        ST_ALARM  = 3'h7
    } pkdm_state_t;

endpackage

`default_nettype wire

// File: rtl/pkdm_key_filter.sv
/*
 * Debounce and edge detection for a group of panel keys.
 * Assumes the raw key levels are already synchronous to clock, active high.
 */
`default_nettype none

module pkdm_key_filter #(
    parameter int          N    = 5,
    parameter logic [32:0] STAB = pkdm_pkg::DEBOUNCE_CYC
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [N-1:0] raw,
    output logic      [N-1:0] level,
    output logic      [N-1:0] press,
    output logic      [N-1:0] release_p
);

    logic [32:0] cnt [N];

    // A key changes its filtered level only after the raw level has differed
    // for STAB cycles, so contact bounce gives one press and one release.
    always_ff @(posedge clock) begin
        for (int i = 0; i < N; i++) begin
            if (rst) begin
                cnt[i]       <= 33'h0;
                level[i]     <= 1'b0;
                press[i]     <= 1'b0;
                release_p[i] <= 1'b0;
            end else begin
                press[i]     <= 1'b0;
                release_p[i] <= 1'b0;
                if (raw[i] == level[i]) begin
                    cnt[i] <= 33'h0;
                end else if (cnt[i] == STAB - 33'h1) begin
                    cnt[i]       <= 33'h0;
                    level[i]     <= raw[i];
                    press[i]     <= raw[i];
                    release_p[i] <= ~raw[i];
                end else begin
                    cnt[i] <= cnt[i] + 33'h1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: rtl/pkdm_panel.sv
/*
 * Front-panel menu controller: five keys in, display content out. It runs the
 * boot, monitor, parameter, editing, save and alarm modes, and formats values.
 * Assumes the parameter store answers save_req with one save_done pulse and
 * that a renderer turns disp_kind, disp_value and the point masks into segments.
 */
`default_nettype none

module pkdm_panel #(
    parameter logic [32:0] SHOW_CYC     = pkdm_pkg::SHOW_CYC,
    parameter logic [32:0] IDLE_CYC     = pkdm_pkg::IDLE_CYC,
    parameter logic [32:0] HOLD_CYC     = pkdm_pkg::HOLD_CYC,
    parameter logic [32:0] DEBOUNCE_CYC = pkdm_pkg::DEBOUNCE_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        key_mode,
    input  wire logic        key_shift,
    input  wire logic        key_up,
    input  wire logic        key_down,
    input  wire logic        key_set,
    input  wire logic        alarm_active,
    input  wire logic        alarm_new,
    input  wire logic [11:0] alarm_code,
    input  wire logic [31:0] mon_value,
    input  wire logic        mon_wide,
    input  wire logic [31:0] param_value,
    input  wire logic [31:0] param_min,
    input  wire logic [31:0] param_max,
    input  wire logic        save_done,
    input  wire logic [2:0]  save_status,
    output logic      [4:0]  mon_sel,
    output logic      [3:0]  param_group,
    output logic      [7:0]  param_num,
    output logic      [31:0] edit_value,
    output logic             save_req,
    output logic      [2:0]  disp_kind,
    output logic      [31:0] disp_value,
    output logic             disp_hex,
    output logic             alarm_prefix_symbol,
    output logic      [4:0]  disp_dp,
    output logic      [4:0]  disp_blink
);

    pkdm_pkg::pkdm_state_t state, next_state;
    logic [4:0]  lvl, prs, rel;
    logic [32:0] tmr, idle_cnt, hold_cnt;
    logic [2:0]  cursor, result;
    logic        hex_sel, half_high, hold_used;
    logic [31:0] neg_edit;
    logic        tmr_hit, idle_hit, any_press, neg_ok;
    logic [31:0] mon_ext;
    logic        mon_neg;

    // Power of ten for the blinking digit; up and down both use it.
    function automatic logic [31:0] pkdm_pow10(input logic [2:0] d);
        case (d)
            3'h0:    pkdm_pow10 = 32'h1;
            3'h1:    pkdm_pow10 = 32'hA;
            3'h2:    pkdm_pow10 = 32'h64;
            3'h3:    pkdm_pow10 = 32'h3E8;
            default: pkdm_pow10 = 32'h2710;
        endcase
    endfunction

    pkdm_key_filter #(
        .N    (pkdm_pkg::N_KEYS),
        .STAB (DEBOUNCE_CYC)
    ) u_keys (
        .clock     (clock),
        .rst       (rst),
        .raw       ({key_set, key_down, key_up, key_shift, key_mode}),
        .level     (lvl),
        .press     (prs),
        .release_p (rel)
    );

    // Timer ends, the negated edit value and the widened monitor value.
    // A 16-bit monitor value is signed, so it is widened by its sign bit.
    assign mon_ext   = mon_wide ? mon_value : {{16{mon_value[15]}}, mon_value[15:0]};
    assign mon_neg   = !hex_sel && mon_ext[31];
    assign tmr_hit   = (tmr == SHOW_CYC - 33'h1);
    assign idle_hit  = (idle_cnt == IDLE_CYC - 33'h1);
    assign any_press = |prs;
    assign neg_edit  = 32'h0 - edit_value;
    assign neg_ok    = ($signed(neg_edit) >= $signed(param_min))
                     && ($signed(neg_edit) <= $signed(param_max));

    // Mode sequencing. An alarm event outranks every key, so it is tested first.
    always_comb begin
        next_state = state;
        if (alarm_new) begin
            next_state = pkdm_pkg::ST_ALARM;
        end else if (idle_hit) begin
            next_state = pkdm_pkg::ST_ALARM;
        end else begin
            case (state)
                pkdm_pkg::ST_BOOT, pkdm_pkg::ST_MONSYM: begin
                    if (tmr_hit) next_state = pkdm_pkg::ST_MON;
                end
                pkdm_pkg::ST_MON: begin
                    if (prs[pkdm_pkg::K_MODE]) begin
                        next_state = alarm_active ? pkdm_pkg::ST_ALARM
                                                  : pkdm_pkg::ST_PARAM;
                    end else if (prs[pkdm_pkg::K_UP] || prs[pkdm_pkg::K_DOWN]) begin
                        next_state = pkdm_pkg::ST_MONSYM;
                    end
                end
                pkdm_pkg::ST_PARAM: begin
                    if (prs[pkdm_pkg::K_MODE]) next_state = pkdm_pkg::ST_MON;
                    else if (prs[pkdm_pkg::K_SET]) next_state = pkdm_pkg::ST_EDIT;
                end
                pkdm_pkg::ST_EDIT: begin
                    if (prs[pkdm_pkg::K_MODE]) next_state = pkdm_pkg::ST_PARAM;
                    else if (prs[pkdm_pkg::K_SET]) next_state = pkdm_pkg::ST_SAVEW;
                end
                pkdm_pkg::ST_SAVEW: begin
                    if (save_done) next_state = pkdm_pkg::ST_RESULT;
                end
                pkdm_pkg::ST_RESULT: begin
                    if (tmr_hit) begin
                        next_state = (result == pkdm_pkg::RES_SAVED)
                                   ? pkdm_pkg::ST_PARAM : pkdm_pkg::ST_EDIT;
                    end
                end
                pkdm_pkg::ST_ALARM: begin
                    if (prs[pkdm_pkg::K_MODE]) next_state = pkdm_pkg::ST_PARAM;
                end
                default: next_state = pkdm_pkg::ST_BOOT;
            endcase
        end
    end

    // State register and the one-second display timer, restarted on each move.
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= pkdm_pkg::ST_BOOT;
            tmr   <= 33'h0;
        end else begin
            state <= next_state;
            tmr   <= (next_state != state || tmr_hit) ? 33'h0 : tmr + 33'h1;
        end
    end

    // Idle timer runs only while an alarm is pending away from the alarm view.
    always_ff @(posedge clock) begin
        if (rst || !alarm_active || any_press || state == pkdm_pkg::ST_ALARM
                || idle_hit) begin
            idle_cnt <= 33'h0;
        end else begin
            idle_cnt <= idle_cnt + 33'h1;
        end
    end

    // Monitor selection, number format and shown half.
    always_ff @(posedge clock) begin
        if (rst) begin
            mon_sel   <= 5'h0;
            hex_sel   <= 1'b0;
            half_high <= 1'b0;
        end else if (state == pkdm_pkg::ST_MON && !alarm_new && !idle_hit) begin
            if (prs[pkdm_pkg::K_UP]) begin
                mon_sel <= (mon_sel == pkdm_pkg::MON_COUNT - 5'h1) ? 5'h0 : mon_sel + 5'h1;
            end else if (prs[pkdm_pkg::K_DOWN]) begin
                mon_sel <= (mon_sel == 5'h0) ? pkdm_pkg::MON_COUNT - 5'h1 : mon_sel - 5'h1;
            end
            if (prs[pkdm_pkg::K_SET]) hex_sel <= ~hex_sel;
            if (prs[pkdm_pkg::K_SHIFT]) half_high <= ~half_high;
        end
    end

    // Parameter group and number selection.
    always_ff @(posedge clock) begin
        if (rst) begin
            param_group <= 4'h0;
            param_num   <= 8'h0;
        end else if (state == pkdm_pkg::ST_PARAM && !alarm_new && !idle_hit) begin
            if (prs[pkdm_pkg::K_SHIFT]) begin
                param_group <= (param_group == pkdm_pkg::GROUP_COUNT - 4'h1)
                             ? 4'h0 : param_group + 4'h1;
            end
            if (prs[pkdm_pkg::K_UP]) begin
                param_num <= (param_num == pkdm_pkg::PNUM_COUNT - 8'h1)
                           ? 8'h0 : param_num + 8'h1;
            end else if (prs[pkdm_pkg::K_DOWN]) begin
                param_num <= (param_num == 8'h0)
                           ? pkdm_pkg::PNUM_COUNT - 8'h1 : param_num - 8'h1;
            end
        end
    end

    // Editing. A short shift acts on release so a long hold can claim it instead.
    always_ff @(posedge clock) begin
        if (rst) begin
            edit_value <= 32'h0;
            cursor     <= 3'h0;
            hold_cnt   <= 33'h0;
            hold_used  <= 1'b0;
        end else if (state == pkdm_pkg::ST_PARAM && prs[pkdm_pkg::K_SET]) begin
            edit_value <= param_value;
            cursor     <= 3'h0;
            hold_cnt   <= 33'h0;
            hold_used  <= 1'b0;
        end else if (state == pkdm_pkg::ST_EDIT) begin
            if (prs[pkdm_pkg::K_UP]) edit_value <= edit_value + pkdm_pow10(cursor);
            else if (prs[pkdm_pkg::K_DOWN]) edit_value <= edit_value - pkdm_pow10(cursor);
            hold_cnt <= lvl[pkdm_pkg::K_SHIFT] && !hold_used ? hold_cnt + 33'h1 : 33'h0;
            if (lvl[pkdm_pkg::K_SHIFT] && !hold_used && hold_cnt == HOLD_CYC - 33'h1) begin
                hold_used <= 1'b1;
                if (neg_ok) edit_value <= neg_edit;
            end
            if (rel[pkdm_pkg::K_SHIFT]) begin
                hold_used <= 1'b0;
                // A release in the very cycle the hold fires must not also move.
                if (!hold_used && hold_cnt != HOLD_CYC - 33'h1) begin
                    cursor <= (cursor == 3'h4) ? 3'h0 : cursor + 3'h1;
                end
            end
        end else begin
            hold_cnt  <= 33'h0;
            hold_used <= 1'b0;
        end
    end

    // Save handshake and the result that the store reports.
    always_ff @(posedge clock) begin
        if (rst) begin
            save_req <= 1'b0;
            result   <= pkdm_pkg::RES_SAVED;
        end else begin
            save_req <= (state == pkdm_pkg::ST_EDIT) && (next_state == pkdm_pkg::ST_SAVEW);
            if (state == pkdm_pkg::ST_SAVEW && save_done) result <= save_status;
        end
    end

    // Display content, one cycle behind the state. Decimal values go out as a
    // magnitude so the renderer never has to handle a sign itself.
    always_ff @(posedge clock) begin
        if (rst) begin
            disp_kind           <= 3'h0;
            disp_value          <= 32'h0;
            disp_hex            <= 1'b0;
            alarm_prefix_symbol <= 1'b0;
            disp_dp             <= 5'h0;
            disp_blink          <= 5'h0;
        end else begin
            disp_kind           <= state;
            alarm_prefix_symbol <= (state == pkdm_pkg::ST_ALARM);
            disp_hex            <= (state == pkdm_pkg::ST_MON) && hex_sel;
            disp_blink          <= (state == pkdm_pkg::ST_EDIT) ? 5'h1 << cursor : 5'h0;
            disp_dp             <= 5'h0;
            case (state)
                pkdm_pkg::ST_MON: begin
                    disp_value <= mon_neg ? 32'h0 - mon_ext : mon_ext;
                    disp_dp <= {mon_neg, mon_neg, 1'b0,
                                !hex_sel && mon_wide && half_high,
                                !hex_sel && mon_wide && !half_high};
                end
                pkdm_pkg::ST_EDIT: begin
                    disp_value <= edit_value[31] ? neg_edit : edit_value;
                    disp_dp    <= {edit_value[31], edit_value[31], 3'h0};
                end
                pkdm_pkg::ST_BOOT, pkdm_pkg::ST_MONSYM: disp_value <= {27'h0, mon_sel};
                pkdm_pkg::ST_PARAM:  disp_value <= {20'h0, param_group, param_num};
                pkdm_pkg::ST_RESULT: disp_value <= {29'h0, result};
                pkdm_pkg::ST_ALARM:  disp_value <= {20'h0, alarm_code};
                default:             disp_value <= 32'h0;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_calm;
        !alarm_new && !idle_hit;
    endsequence

    sequence s_save_ok;
        state == pkdm_pkg::ST_RESULT && result == pkdm_pkg::RES_SAVED && tmr_hit;
    endsequence

    a_boot_to_mon: assert property (
        state == pkdm_pkg::ST_BOOT && tmr_hit && !alarm_new && !idle_hit
        |=> state == pkdm_pkg::ST_MON)
        else $error("boot did not reach monitor");
    a_mode_order: assert property (
        state == pkdm_pkg::ST_PARAM && prs[pkdm_pkg::K_MODE] and s_calm
        |=> state == pkdm_pkg::ST_MON)
        else $error("mode order broken");
    a_alarm_force: assert property (
        alarm_new |=> state == pkdm_pkg::ST_ALARM
        ##1 disp_kind == pkdm_pkg::ST_ALARM && alarm_prefix_symbol)
        else $error("alarm not forced");
    a_mon_select: assert property (
        state == pkdm_pkg::ST_MON && prs[pkdm_pkg::K_UP] && !prs[pkdm_pkg::K_MODE]
        and s_calm |=> state == pkdm_pkg::ST_MONSYM && mon_sel != $past(mon_sel))
        else $error("monitor select failed");
    a_set_edit: assert property (
        state == pkdm_pkg::ST_PARAM && prs[pkdm_pkg::K_SET] && !prs[pkdm_pkg::K_MODE]
        and s_calm |=> state == pkdm_pkg::ST_EDIT && edit_value == $past(param_value))
        else $error("edit entry wrong");
    a_save_back: assert property (
        s_save_ok and s_calm |=> state == pkdm_pkg::ST_PARAM)
        else $error("successful save did not return");
    a_save_req: assert property (
        state == pkdm_pkg::ST_EDIT && prs[pkdm_pkg::K_SET] && !prs[pkdm_pkg::K_MODE]
        and s_calm |=> save_req ##1 !save_req)
        else $error("save request not a single pulse");
    a_hex_toggle: assert property (
        state == pkdm_pkg::ST_MON && prs[pkdm_pkg::K_SET]
        and s_calm |=> hex_sel != $past(hex_sel))
        else $error("format not toggled");
    a_hex_nosign: assert property (
        disp_hex |-> disp_dp[4:3] == 2'h0)
        else $error("hex display shows a sign");

endmodule

`default_nettype wire

// File: verif/pkdm_operator.sv
/*
 * Operator and parameter store model for the panel bench: it presses keys by
 * holding raw levels and answers every save request with one done pulse.
 * Assumes the bench calls press and sets res before each save.
 */
`default_nettype none

module pkdm_operator (
    input  wire logic       clock,
    input  wire logic       save_req,
    output logic            key_mode,
    output logic            key_shift,
    output logic            key_up,
    output logic            key_down,
    output logic            key_set,
    output logic            save_done,
    output logic      [2:0] save_status
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] keys  = 5'h00;
    logic [2:0] res   = 3'h0;
    int         saves = 0;

    // The key lines share one vector so that press can pick them by index.
    assign key_mode  = keys[pkdm_pkg::K_MODE];
    assign key_shift = keys[pkdm_pkg::K_SHIFT];
    assign key_up    = keys[pkdm_pkg::K_UP];
    assign key_down  = keys[pkdm_pkg::K_DOWN];
    assign key_set   = keys[pkdm_pkg::K_SET];

    // A press holds the level well past the debounce time, then lets go and rests.
    task automatic press(input int k, input int hold);
        @(negedge clock);
        keys[k] = 1'b1;
        repeat (hold) @(negedge clock);
        keys[k] = 1'b0;
        repeat (8) @(negedge clock);
    endtask

    // The store answers one cycle late; outside the pulse the status shows 3'h7
    // before any save, then the inverse of the last result, so a stale sample never equals that result.
    initial begin
        save_done   = 1'b0;
        save_status = 3'h7;
        forever begin
            @(negedge clock);
            if (save_req === 1'b1) begin
                saves++;
                @(negedge clock);
                save_done   = 1'b1;
                save_status = res;
                @(negedge clock);
                save_done   = 1'b0;
                save_status = ~res;
            end
        end
    end
endmodule

`default_nettype wire

// File: verif/tb_pkdm_panel.sv
/*
 * Self-checking bench for the panel menu controller, one task per scenario.
 * Assumes the operator model in pkdm_operator and shortened time parameters.
 */
`default_nettype none

module tb_pkdm_panel;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [32:0] SHOW = 33'h014;
    localparam logic [32:0] IDLE = 33'h0C8;
    localparam logic [32:0] HOLD = 33'h028;
    localparam int          KM   = pkdm_pkg::K_MODE;
    localparam int          KH   = pkdm_pkg::K_SHIFT;
    localparam int          KU   = pkdm_pkg::K_UP;
    localparam int          KD   = pkdm_pkg::K_DOWN;
    localparam int          KS   = pkdm_pkg::K_SET;

    logic        clock        = 1'b0;
    logic        rst          = 1'b1;
    logic        alarm_active = 1'b0;
    logic        alarm_new    = 1'b0;
    logic [11:0] alarm_code   = 12'h000;
    logic [31:0] mon_value    = 32'h0000FFFF;
    logic        mon_wide     = 1'b0;
    logic [31:0] param_value  = 32'h00000064;
    logic [31:0] param_min    = 32'hFFFFFC18;
    logic [31:0] param_max    = 32'h000003E8;
    logic        key_mode, key_shift, key_up, key_down, key_set, save_done, save_req;
    logic        disp_hex, alarm_prefix_symbol;
    logic [2:0]  save_status, disp_kind;
    logic [4:0]  mon_sel, disp_dp, disp_blink;
    logic [3:0]  param_group;
    logic [7:0]  param_num;
    logic [31:0] edit_value, disp_value;
    int          bad_count = 0;
    int          checks    = 0;
    int          cycles    = 0;

    pkdm_panel #(.SHOW_CYC(SHOW), .IDLE_CYC(IDLE), .HOLD_CYC(HOLD), .DEBOUNCE_CYC(33'h003)) DUT (
        .clock(clock), .rst(rst), .key_mode(key_mode), .key_shift(key_shift),
        .key_up(key_up), .key_down(key_down), .key_set(key_set),
        .alarm_active(alarm_active), .alarm_new(alarm_new), .alarm_code(alarm_code),
        .mon_value(mon_value), .mon_wide(mon_wide), .param_value(param_value),
        .param_min(param_min), .param_max(param_max), .save_done(save_done),
        .save_status(save_status), .mon_sel(mon_sel), .param_group(param_group),
        .param_num(param_num), .edit_value(edit_value), .save_req(save_req),
        .disp_kind(disp_kind), .disp_value(disp_value), .disp_hex(disp_hex),
        .alarm_prefix_symbol(alarm_prefix_symbol), .disp_dp(disp_dp), .disp_blink(disp_blink));

    pkdm_operator u_op (
        .clock(clock), .save_req(save_req), .key_mode(key_mode), .key_shift(key_shift),
        .key_up(key_up), .key_down(key_down), .key_set(key_set),
        .save_done(save_done), .save_status(save_status));

    // Free-running 250 MHz clock.
    initial forever #2 clock = ~clock;

    // Cycle ceiling cuts a hang short and still reaches the closing report.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            results();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic t_boot();
        repeat (2) @(negedge clock);
        check("boot_kind", 32'(disp_kind === pkdm_pkg::ST_MON), 32'h0);
        repeat (SHOW + 33'h5) @(negedge clock);
        check("boot_end", disp_kind, pkdm_pkg::ST_MON);
        $display("test boot done");
    endtask

    task automatic t_monitor();
        check("neg_dp", disp_dp[4:3], 32'h3);
        check("neg_mag", disp_value, 32'h1);
        u_op.press(KU, 6);
        check("mon_up", mon_sel, 32'h1);
        check("mon_sym", disp_kind, pkdm_pkg::ST_MONSYM);
        repeat (SHOW) @(negedge clock);
        check("mon_back", disp_kind, pkdm_pkg::ST_MON);
        u_op.press(KD, 6);
        repeat (SHOW) @(negedge clock);
        check("mon_down", mon_sel, 32'h0);
        u_op.press(KS, 6);
        check("hex_on", disp_hex, 32'h1);
        check("hex_nosign", disp_dp[4:3], 32'h0);
        u_op.press(KS, 6);
        check("hex_off", disp_hex, 32'h0);
        mon_wide  = 1'b1;
        mon_value = 32'h00000005;
        repeat (3) @(negedge clock);
        check("half_low", disp_dp[1:0], 32'h1);
        u_op.press(KH, 6);
        check("half_high", disp_dp[1:0], 32'h2);
        $display("test monitor done");
    endtask

    task automatic t_param();
        u_op.press(KM, 6);
        check("to_param", disp_kind, pkdm_pkg::ST_PARAM);
        u_op.press(KH, 6);
        check("group", param_group, 32'h1);
        u_op.press(KU, 6);
        u_op.press(KU, 6);
        check("num_up", param_num, 32'h2);
        u_op.press(KD, 6);
        check("num_down", param_num, 32'h1);
        check("code_show", disp_value, 32'h00000101);
        $display("test param done");
    endtask

    task automatic t_edit();
        int n;
        logic [2:0] r;
        logic [31:0] e;
        u_op.press(KS, 6);
        check("edit_kind", disp_kind, pkdm_pkg::ST_EDIT);
        check("edit_load", edit_value, 32'h64);
        check("blink0", disp_blink, 32'h1);
        u_op.press(KU, 6);
        check("digit_up", edit_value, 32'h65);
        u_op.press(KH, 6);
        check("blink1", disp_blink, 32'h2);
        u_op.press(KU, 6);
        check("tens_up", edit_value, 32'h6F);
        u_op.press(KH, int'(HOLD) + 10);
        check("sign_flip", edit_value, 32'hFFFFFF91);
        check("hold_nomove", disp_blink, 32'h2);
        check("edit_sign", disp_dp[4:3], 32'h3);
        check("edit_mag", disp_value, 32'h6F);
        param_max = 32'h00000064;
        u_op.press(KH, int'(HOLD) + 10);
        check("sign_refused", edit_value, 32'hFFFFFF91);
        for (int i = 1; i <= 6; i++) begin
            r = 3'(i % 6);
            u_op.res = r;
            n = u_op.saves;
            u_op.press(KS, 6);
            check("save_once", u_op.saves, n + 1);
            check("res_kind", disp_kind, pkdm_pkg::ST_RESULT);
            check("res_code", disp_value, 32'(r));
            repeat (SHOW) @(negedge clock);
            e = (r == 3'h0) ? pkdm_pkg::ST_PARAM : pkdm_pkg::ST_EDIT;
            check("res_after", disp_kind, e);
        end
        u_op.press(KS, 6);
        n = u_op.saves;
        u_op.press(KM, 6);
        check("abandon", disp_kind, pkdm_pkg::ST_PARAM);
        check("no_save", u_op.saves, n);
        $display("test edit done");
    endtask

    task automatic t_alarm();
        @(negedge clock);
        alarm_code   = 12'h123;
        alarm_active = 1'b1;
        alarm_new    = 1'b1;
        @(negedge clock);
        alarm_new = 1'b0;
        repeat (3) @(negedge clock);
        check("forced", disp_kind, pkdm_pkg::ST_ALARM);
        check("prefix", alarm_prefix_symbol, 32'h1);
        check("alarm_code", disp_value, 32'h123);
        u_op.press(KM, 6);
        check("leave_alarm", disp_kind, pkdm_pkg::ST_PARAM);
        u_op.press(KM, 6);
        u_op.press(KM, 6);
        check("mode_alarm", disp_kind, pkdm_pkg::ST_ALARM);
        u_op.press(KM, 6);
        repeat (IDLE - 33'h1E) @(negedge clock);
        check("idle_wait", disp_kind, pkdm_pkg::ST_PARAM);
        repeat (30) @(negedge clock);
        check("idle_back", disp_kind, pkdm_pkg::ST_ALARM);
        $display("test alarm done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset for four cycles, then the scenarios in menu order.
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        t_boot();
        t_monitor();
        t_param();
        t_edit();
        t_alarm();
        results();
    end
endmodule

`default_nettype wire
